// file: bench/enc_model.sv
`timescale 1ns/1ps
// Encoder and trigger lines facing the counter channel
module enc_model (
  input  wire logic sys_clk,
  output      logic phase_a,
  output      logic phase_b,
  output      logic index_in,
  output      logic aux_in,
  output      logic gate_in,
  output      logic source_in
);
  int         gap = 3;
  logic [1:0] pos = 2'h0;

  // All lines idle low at start
  initial
  begin
    {phase_a, phase_b, index_in} = 3'h0;
    {aux_in, gate_in, source_in} = 3'h0;
  end

  // Move one quadrature phase; index high for part of the new phase
  task automatic step(input logic up, input logic idx);
    @(posedge sys_clk);
    pos = up ? pos + 2'h1 : pos - 2'h1;
    phase_a  <= pos[0] ^ pos[1];
    phase_b  <= pos[1];
    index_in <= idx;
    repeat (gap) @(posedge sys_clk);
    index_in <= 1'b0;
  endtask : step

  // Invert one line: 0 aux, 1 gate, 2 source, 3 phase A, 4 phase B
  task automatic flip(input int which);
    case (which)
      0: aux_in <= ~aux_in;
      1: gate_in <= ~gate_in;
      2: source_in <= ~source_in;
      3: phase_a <= ~phase_a;
      default: phase_b <= ~phase_b;
    endcase
  endtask : flip

  // One pulse away from the idle level and back
  task automatic pulse(input int which);
    @(posedge sys_clk);
    flip(which);
    repeat (gap) @(posedge sys_clk);
    flip(which);
    repeat (gap) @(posedge sys_clk);
  endtask : pulse

  // Idle levels of aux, gate and source
  task automatic set_idle(input logic [2:0] lv);
    @(posedge sys_clk);
    {aux_in, gate_in, source_in} <= lv;
    repeat (gap) @(posedge sys_clk);
  endtask : set_idle
endmodule : enc_model

// file: bench/tb_gp_counter_decode_pulse.sv
`timescale 1ns/1ps
module tb_gp_counter_decode_pulse;
  logic                     sys_clk = 1'b0;
  logic                     rstn = 1'b0;
  gp_counter_pkg::bus_req_t bus_req = '0;
  gp_counter_pkg::stream_t  stream_q;
  logic [31:0]              rdata_q;
  logic [31:0]              rd_word;
  logic [31:0]              got_q[$];
  logic                     phase_a, phase_b, index_in;
  logic                     aux_in, gate_in, source_in, pulse_out_q;
  int                       fail_count = 0;
  int                       samples_checked = 0;

  gp_counter_decode_pulse i_gp_counter_decode_pulse (
    .sys_clk(sys_clk), .rstn(rstn), .bus_req(bus_req), .rdata_q(rdata_q),
    .phase_a(phase_a), .phase_b(phase_b), .index_in(index_in),
    .aux_in(aux_in), .gate_in(gate_in), .source_in(source_in),
    .pulse_out_q(pulse_out_q), .stream_q(stream_q)
  );

  enc_model i_enc_model (
    .sys_clk(sys_clk), .phase_a(phase_a), .phase_b(phase_b),
    .index_in(index_in), .aux_in(aux_in), .gate_in(gate_in),
    .source_in(source_in)
  );

  // Clock of 4 ns
  always #2 sys_clk = ~sys_clk;

  // Collect each streamed count
  always @(posedge sys_clk)
  begin
    if (stream_q.valid === 1'b1)
      got_q.push_back(stream_q.data);
  end

  task automatic test_done;
    $display("Counts: %0d mismatches, %0d checks", fail_count,
             samples_checked);
    if (fail_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %0t word %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %0t pulse %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus_req.addr  <= a;
    bus_req.wdata <= d;
    bus_req.wr    <= 1'b1;
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
  endtask : bus_wr

  // Read data stand only in the cycle after the strobe
  task automatic expect_reg(input logic [3:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    bus_req.addr <= a;
    bus_req.rd   <= 1'b1;
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
    #1;
    rd_word = rdata_q;
    chk_word(rd_word, exp);
  endtask : expect_reg

  // Control word with arm clear; pol is {gate, aux, source} falling
  function automatic logic [31:0] ctrl(input logic [2:0] m,
    input logic [1:0] dec, input logic [2:0] pol, input logic rld);
    ctrl = '0;
    ctrl[gp_counter_pkg::CTRL_MODE_HI:gp_counter_pkg::CTRL_MODE_LO] = m;
    ctrl[gp_counter_pkg::CTRL_DEC_HI:gp_counter_pkg::CTRL_DEC_LO] = dec;
    ctrl[gp_counter_pkg::CTRL_GATE_FALL:gp_counter_pkg::CTRL_SRC_FALL] = pol;
    ctrl[gp_counter_pkg::CTRL_RLD_EN] = rld;
  endfunction : ctrl

  task automatic arm(input logic [31:0] c);
    bus_wr(gp_counter_pkg::OFF_CTRL, c);
    bus_wr(gp_counter_pkg::OFF_CTRL, c | 32'h0000_0001);
  endtask : arm

  // Cut a hang short
  initial
  begin
    repeat (30000) @(posedge sys_clk);
    fail_count++;
    $display("ERROR %0t watchdog expired", $time);
    test_done();
  end

  // Main sequence
  initial
  begin
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    expect_reg(4'hf, 32'h0000_0000);
    // Quadrature decoding in all three factors
    for (logic [1:0] d = 2'h0; d < 2'h3; d++)
    begin
      arm(ctrl(gp_counter_pkg::MODE_QUAD, d, 3'h0, 1'b0));
      expect_reg(gp_counter_pkg::OFF_COUNT, 32'h0);
      repeat (8) i_enc_model.step(1'b1, 1'b0);
      expect_reg(gp_counter_pkg::OFF_COUNT, 32'h2 << d);
      repeat (4) i_enc_model.step(1'b0, 1'b0);
      expect_reg(gp_counter_pkg::OFF_COUNT, 32'h1 << d);
    end
    // Index reload in phase A0B0, with wrap of the full width
    bus_wr(gp_counter_pkg::OFF_RELOAD, 32'hffff_fffe);
    arm(ctrl(gp_counter_pkg::MODE_QUAD, gp_counter_pkg::DEC_X4, 3'h0, 1'b1));
    expect_reg(gp_counter_pkg::OFF_COUNT, 32'hffff_fffe);
    repeat (3) i_enc_model.step(1'b1, 1'b0);
    expect_reg(gp_counter_pkg::OFF_COUNT, 32'h0000_0001);
    i_enc_model.step(1'b1, 1'b1);
    expect_reg(gp_counter_pkg::OFF_COUNT, 32'hffff_fffe);
    i_enc_model.step(1'b1, 1'b0);
    i_enc_model.step(1'b1, 1'b1);
    expect_reg(gp_counter_pkg::OFF_COUNT, 32'h0000_0000);
    repeat (2) i_enc_model.step(1'b1, 1'b0);
    expect_reg(gp_counter_pkg::OFF_COUNT, 32'h0000_0002);
    // Two-pulse encoder
    arm(ctrl(gp_counter_pkg::MODE_TWO_PULSE, 2'h0, 3'h0, 1'b0));
    repeat (3) i_enc_model.pulse(3);
    i_enc_model.pulse(4);
    expect_reg(gp_counter_pkg::OFF_COUNT, 32'h0000_0002);
    // Single separation: unarmed edges, extra aux, edges after latch
    bus_wr(gp_counter_pkg::OFF_CTRL,
           ctrl(gp_counter_pkg::MODE_SEP_SINGLE, 2'h0, 3'h0, 1'b0));
    i_enc_model.pulse(0);
    i_enc_model.pulse(2);
    expect_reg(gp_counter_pkg::OFF_STATUS, 32'h0);
    arm(ctrl(gp_counter_pkg::MODE_SEP_SINGLE, 2'h0, 3'h0, 1'b0));
    i_enc_model.pulse(0);
    repeat (3) i_enc_model.pulse(2);
    i_enc_model.pulse(0);
    repeat (2) i_enc_model.pulse(2);
    i_enc_model.pulse(1);
    expect_reg(gp_counter_pkg::OFF_LATCHED, 32'h5);
    i_enc_model.pulse(0);
    repeat (2) i_enc_model.pulse(2);
    i_enc_model.pulse(1);
    expect_reg(gp_counter_pkg::OFF_LATCHED, 32'h5);
    expect_reg(gp_counter_pkg::OFF_COUNT, 32'h5);
    chk_word(32'(got_q.size()), 32'h0);
    // Buffered separation on falling aux and gate, slow partner
    bus_wr(gp_counter_pkg::OFF_CTRL,
           ctrl(gp_counter_pkg::MODE_SEP_BUF, 2'h0, 3'h6, 1'b0));
    i_enc_model.set_idle(3'h6);
    i_enc_model.gap = 7;
    arm(ctrl(gp_counter_pkg::MODE_SEP_BUF, 2'h0, 3'h6, 1'b0));
    i_enc_model.pulse(0);
    repeat (3) i_enc_model.pulse(2);
    i_enc_model.pulse(1);
    i_enc_model.pulse(0);
    repeat (6) i_enc_model.pulse(2);
    i_enc_model.pulse(1);
    i_enc_model.gap = 3;
    chk_word(32'(got_q.size()), 32'h2);
    chk_word(got_q[0], 32'h3);
    chk_word(got_q[1], 32'h6);
    // Single pulse on falling source, delay 4 and width 3
    i_enc_model.set_idle(3'h1);
    bus_wr(gp_counter_pkg::OFF_DELAY, 32'h4);
    bus_wr(gp_counter_pkg::OFF_WIDTH, 32'h3);
    arm(ctrl(gp_counter_pkg::MODE_PULSE, 2'h0, 3'h1, 1'b0));
    for (int i = 1; i < 10; i++)
    begin
      i_enc_model.pulse(2);
      #1;
      chk_bit(pulse_out_q, (i >= 4 && i < 7));
    end
    // Triggered pulse; gate ignored after the first trigger
    arm(ctrl(gp_counter_pkg::MODE_PULSE_TRIG, 2'h0, 3'h1, 1'b0));
    repeat (5)
    begin
      i_enc_model.pulse(2);
      #1;
      chk_bit(pulse_out_q, 1'b0);
    end
    i_enc_model.pulse(1);
    for (int i = 1; i < 17; i++)
    begin
      if (i == 5 || i == 10)
        i_enc_model.pulse(1);
      i_enc_model.pulse(2);
      #1;
      chk_bit(pulse_out_q, (i >= 4 && i < 7));
    end
    test_done();
  end
endmodule : tb_gp_counter_decode_pulse

// file: design/gp_counter_decode_pulse.sv
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps
// What this block does
// - Quadrature counts up when A leads B, down when B leads A.
// - Single-edge decoding, A leading: add one on rising A.
// - Single-edge decoding, B leading: subtract one on falling A.
// - Double-edge decoding counts both A edges, two counts per cycle.
// - Quad-edge decoding counts every A and B edge, four per cycle.
// - Index high during the selected phase loads the reload value.
// - A count entering the reload phase is applied before the reload.
// - Reload within one clock of the phase; counting then resumes.
// - Two-pulse mode: rising A adds one, rising B subtracts one.
// - Edge separation only after arming; unarmed edges are ignored.
// - Aux edge starts counting source edges; later aux edges ignored.
// - Gate edge stops counting and latches the count.
// - Aux and gate active polarities are selectable independently.
// - Single separation ignores all edges after the latch.
// - Buffered separation restarts on the same gate edge that latches the count.
// - Buffered separation streams each latched count in order.
// - Single pulse starts after a delay in source edges from arming.
// - Pulse width in source edges; source edge polarity selectable.
// - Triggered pulse delay counts from a gate start trigger.
// - Triggered pulse ignores the gate after the first trigger.
// - The count value is 32 bits wide.
module gp_counter_decode_pulse (
  input  wire logic                            sys_clk,
  input  wire logic                            rstn,
  input  wire gp_counter_pkg::bus_req_t        bus_req,
  output      logic [gp_counter_pkg::CNT_W-1:0] rdata_q,
  input  wire logic                            phase_a,
  input  wire logic                            phase_b,
  input  wire logic                            index_in,
  input  wire logic                            aux_in,
  input  wire logic                            gate_in,
  input  wire logic                            source_in,
  output      logic                            pulse_out_q,
  output      gp_counter_pkg::stream_t         stream_q
);

  typedef enum logic [1:0] {S_IDLE, S_RUN, S_PULSE, S_DONE} st_t;

  logic [gp_counter_pkg::CTRL_W-1:0] ctrl_q;
  logic [gp_counter_pkg::CNT_W-1:0]  reload_q;
  logic [gp_counter_pkg::CNT_W-1:0]  delay_q;
  logic [gp_counter_pkg::CNT_W-1:0]  width_q;
  logic [gp_counter_pkg::CNT_W-1:0]  count_q;
  logic [gp_counter_pkg::CNT_W-1:0]  count_d;
  logic [gp_counter_pkg::CNT_W-1:0]  latched_q;
  logic                              latch_new_q;
  logic [2:0]                        a_q;
  logic [2:0]                        b_q;
  logic [2:0]                        other_q;
  logic [1:0]                        in_q;
  st_t                               st_q;
  st_t                               st_d;
  logic                              arm_pulse;
  logic                              latch_now;

  gp_counter_pkg::mode_t   mode;
  gp_counter_pkg::decode_t dec;
  logic       armed;
  logic [1:0] rl_phase;
  logic       a_r, a_f, b_r, b_f, src_act, aux_act, gate_act;
  logic       q_up, q_dn, in_phase;

  assign armed    = ctrl_q[gp_counter_pkg::CTRL_ARM];
  assign mode     = gp_counter_pkg::mode_t'(
    ctrl_q[gp_counter_pkg::CTRL_MODE_HI:gp_counter_pkg::CTRL_MODE_LO]);
  assign dec      = gp_counter_pkg::decode_t'(
    ctrl_q[gp_counter_pkg::CTRL_DEC_HI:gp_counter_pkg::CTRL_DEC_LO]);
  assign rl_phase = ctrl_q[gp_counter_pkg::CTRL_PH_HI:gp_counter_pkg::CTRL_PH_LO];

  // Input history for edge detection
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      a_q     <= 3'h0;
      b_q     <= 3'h0;
      other_q <= 3'h0;
    end
    else
    begin
      a_q     <= {a_q[1:0], phase_a};
      b_q     <= {b_q[1:0], phase_b};
      other_q <= {aux_in, gate_in, source_in};
    end
  end

  // Edges of the current inputs against last cycle
  assign a_r = phase_a & ~a_q[0];
  assign a_f = ~phase_a & a_q[0];
  assign b_r = phase_b & ~b_q[0];
  assign b_f = ~phase_b & b_q[0];
  // Selectable active edges
  assign src_act  = ctrl_q[gp_counter_pkg::CTRL_SRC_FALL] ?
                    (~source_in & other_q[0]) : (source_in & ~other_q[0]);
  assign aux_act  = ctrl_q[gp_counter_pkg::CTRL_AUX_FALL] ?
                    (~aux_in & other_q[2]) : (aux_in & ~other_q[2]);
  assign gate_act = ctrl_q[gp_counter_pkg::CTRL_GATE_FALL] ?
                    (~gate_in & other_q[1]) : (gate_in & ~other_q[1]);

  // Quadrature direction from which channel moved relative to the other
  always_comb
  begin
    q_up = 1'b0;
    q_dn = 1'b0;
    case (dec)
      gp_counter_pkg::DEC_X1:
      begin
        q_up = a_r & ~phase_b;
        q_dn = a_f & ~phase_b;
      end
      gp_counter_pkg::DEC_X2:
      begin
        q_up = (a_r & ~phase_b) | (a_f & phase_b);
        q_dn = (a_f & ~phase_b) | (a_r & phase_b);
      end
      default:
      begin
        q_up = (a_r & ~phase_b) | (a_f & phase_b) |
               (b_r & phase_a) | (b_f & ~phase_a);
        q_dn = (a_f & ~phase_b) | (a_r & phase_b) |
               (b_f & phase_a) | (b_r & ~phase_a);
      end
    endcase
  end

  // Phase 0: A low B low, 1: A high B low, 2: both high, 3: A low B high
  always_comb
  begin
    case (rl_phase)
      2'h0:    in_phase = ~phase_a & ~phase_b;
      2'h1:    in_phase =  phase_a & ~phase_b;
      2'h2:    in_phase =  phase_a &  phase_b;
      default: in_phase = ~phase_a &  phase_b;
    endcase
  end

  assign arm_pulse = bus_req.wr && (bus_req.addr == gp_counter_pkg::OFF_CTRL)
                     && bus_req.wdata[gp_counter_pkg::CTRL_ARM];
  assign latch_now = (st_q == S_RUN) && gate_act &&
                     ((mode == gp_counter_pkg::MODE_SEP_SINGLE) ||
                      (mode == gp_counter_pkg::MODE_SEP_BUF));

  // Channel state machine
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      S_IDLE:
      begin
        if (armed)
        begin
          case (mode)
            gp_counter_pkg::MODE_SEP_SINGLE,
            gp_counter_pkg::MODE_SEP_BUF:
              if (aux_act) st_d = S_RUN;
            gp_counter_pkg::MODE_PULSE:
              st_d = S_RUN;
            gp_counter_pkg::MODE_PULSE_TRIG:
              if (gate_act) st_d = S_RUN;
            default:
              st_d = S_IDLE;
          endcase
        end
      end
      S_RUN:
      begin
        if (latch_now)
          // Buffered: the stopping gate edge also opens the next interval
          st_d = (mode == gp_counter_pkg::MODE_SEP_BUF) ? S_RUN : S_DONE;
        else if ((mode == gp_counter_pkg::MODE_PULSE ||
                  mode == gp_counter_pkg::MODE_PULSE_TRIG) &&
                 src_act && (count_q + gp_counter_pkg::CNT_ONE >= delay_q))
          st_d = S_PULSE;
      end
      S_PULSE:
      begin
        if (src_act && (count_q + gp_counter_pkg::CNT_ONE >= width_q))
          st_d = S_DONE;
      end
      default:
        st_d = S_DONE;
    endcase
    if (!armed)
      st_d = S_IDLE;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      st_q <= S_IDLE;
    else
      st_q <= st_d;
  end

  // Working count update
  always_comb
  begin
    count_d = count_q;
    case (mode)
      gp_counter_pkg::MODE_QUAD:
      begin
        if (armed && q_up)
          count_d = count_q + gp_counter_pkg::CNT_ONE;
        else if (armed && q_dn)
          count_d = count_q - gp_counter_pkg::CNT_ONE;
        // Reload only once the phase is settled, after any count
        if (armed && ctrl_q[gp_counter_pkg::CTRL_RLD_EN] && index_in &&
            in_phase && !q_up && !q_dn)
          count_d = reload_q;
      end
      gp_counter_pkg::MODE_TWO_PULSE:
      begin
        if (armed && a_r && !b_r)
          count_d = count_q + gp_counter_pkg::CNT_ONE;
        else if (armed && b_r && !a_r)
          count_d = count_q - gp_counter_pkg::CNT_ONE;
      end
      default:
      begin
        if (latch_now && mode == gp_counter_pkg::MODE_SEP_BUF)
          count_d = gp_counter_pkg::CNT_ZERO;
        else if (st_q == S_RUN && st_d == S_PULSE)
          count_d = gp_counter_pkg::CNT_ZERO;
        else if (st_q == S_IDLE && st_d == S_RUN)
          count_d = gp_counter_pkg::CNT_ZERO;
        else if ((st_q == S_RUN || st_q == S_PULSE) && src_act && !latch_now)
          count_d = count_q + gp_counter_pkg::CNT_ONE;
      end
    endcase
    if (arm_pulse)
      count_d = ctrl_q[gp_counter_pkg::CTRL_RLD_EN] ? reload_q
                                                   : gp_counter_pkg::CNT_ZERO;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      count_q <= gp_counter_pkg::CNT_ZERO;
    else
      count_q <= count_d;
  end

  // Latched count and stream output
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      latched_q   <= gp_counter_pkg::CNT_ZERO;
      latch_new_q <= 1'b0;
      stream_q    <= '0;
    end
    else
    begin
      stream_q.valid <= 1'b0;
      if (latch_now)
      begin
        latched_q   <= count_q;
        latch_new_q <= 1'b1;
        if (mode == gp_counter_pkg::MODE_SEP_BUF)
        begin
          stream_q.valid <= 1'b1;
          stream_q.data  <= count_q;
        end
      end
      else if (bus_req.rd && bus_req.addr == gp_counter_pkg::OFF_LATCHED)
        latch_new_q <= 1'b0;
    end
  end

  // Pulse output
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      pulse_out_q <= 1'b0;
    else
      pulse_out_q <= (st_d == S_PULSE);
  end

  // Register writes
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_q   <= '0;
      reload_q <= gp_counter_pkg::CNT_ZERO;
      delay_q  <= gp_counter_pkg::CNT_ZERO;
      width_q  <= gp_counter_pkg::CNT_ZERO;
    end
    else if (bus_req.wr)
    begin
      if (bus_req.addr == gp_counter_pkg::OFF_CTRL)
        ctrl_q <= bus_req.wdata[gp_counter_pkg::CTRL_W-1:0];
      else if (bus_req.addr == gp_counter_pkg::OFF_RELOAD)
        reload_q <= bus_req.wdata;
      else if (bus_req.addr == gp_counter_pkg::OFF_DELAY)
        delay_q <= bus_req.wdata;
      else if (bus_req.addr == gp_counter_pkg::OFF_WIDTH)
        width_q <= bus_req.wdata;
    end
  end

  // Register reads, data one cycle after the strobe
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      rdata_q <= gp_counter_pkg::CNT_ZERO;
    else if (bus_req.rd)
    begin
      if (bus_req.addr == gp_counter_pkg::OFF_CTRL)
        rdata_q <= {20'h00000, ctrl_q};
      else if (bus_req.addr == gp_counter_pkg::OFF_RELOAD)
        rdata_q <= reload_q;
      else if (bus_req.addr == gp_counter_pkg::OFF_DELAY)
        rdata_q <= delay_q;
      else if (bus_req.addr == gp_counter_pkg::OFF_WIDTH)
        rdata_q <= width_q;
      else if (bus_req.addr == gp_counter_pkg::OFF_COUNT)
        rdata_q <= count_q;
      else if (bus_req.addr == gp_counter_pkg::OFF_LATCHED)
        rdata_q <= latched_q;
      else if (bus_req.addr == gp_counter_pkg::OFF_STATUS)
        rdata_q <= {27'h0000000, latch_new_q, pulse_out_q,
                    (st_q == S_DONE), (st_q == S_RUN), armed};
      else
        rdata_q <= gp_counter_pkg::CNT_ZERO;
    end
    else
      rdata_q <= gp_counter_pkg::CNT_ZERO;
  end

  // Checks
  sequence s_armed_quad;
    armed && mode == gp_counter_pkg::MODE_QUAD;
  endsequence

  property p_quad_up;
    @(posedge sys_clk) disable iff (!rstn)
    (s_armed_quad and q_up && !arm_pulse && !index_in)
      |=> count_q == $past(count_q) + gp_counter_pkg::CNT_ONE;
  endproperty
  a_quad_up: assert property (p_quad_up)
    else $error("quadrature up count missing");

  property p_quad_dn;
    @(posedge sys_clk) disable iff (!rstn)
    (s_armed_quad and q_dn && !arm_pulse && !index_in)
      |=> count_q == $past(count_q) - gp_counter_pkg::CNT_ONE;
  endproperty
  a_quad_dn: assert property (p_quad_dn)
    else $error("quadrature down count missing");

  property p_x1_rise;
    @(posedge sys_clk) disable iff (!rstn)
    (s_armed_quad and dec == gp_counter_pkg::DEC_X1 && a_r && !phase_b)
      |-> q_up;
  endproperty
  a_x1_rise: assert property (p_x1_rise)
    else $error("single-edge rising A not counted");

  property p_reload;
    @(posedge sys_clk) disable iff (!rstn)
    (s_armed_quad and ctrl_q[gp_counter_pkg::CTRL_RLD_EN] && index_in &&
     in_phase && !q_up && !q_dn && !arm_pulse) |=> count_q == $past(reload_q);
  endproperty
  a_reload: assert property (p_reload)
    else $error("index reload not applied");

  property p_two_pulse;
    @(posedge sys_clk) disable iff (!rstn)
    (armed && mode == gp_counter_pkg::MODE_TWO_PULSE && a_r && !b_r &&
     !arm_pulse) |=> count_q == $past(count_q) + gp_counter_pkg::CNT_ONE;
  endproperty
  a_two_pulse: assert property (p_two_pulse)
    else $error("two-pulse up count missing");

  property p_unarmed;
    @(posedge sys_clk) disable iff (!rstn)
    !armed |=> st_q == S_IDLE;
  endproperty
  a_unarmed: assert property (p_unarmed)
    else $error("channel active while unarmed");

  property p_latch;
    @(posedge sys_clk) disable iff (!rstn)
    latch_now |=> latched_q == $past(count_q);
  endproperty
  a_latch: assert property (p_latch)
    else $error("latched count wrong");

  property p_stream;
    @(posedge sys_clk) disable iff (!rstn)
    (latch_now && mode == gp_counter_pkg::MODE_SEP_BUF)
      |=> stream_q.valid && stream_q.data == latched_q;
  endproperty
  a_stream: assert property (p_stream)
    else $error("buffered count not streamed");

  property p_done_hold;
    @(posedge sys_clk) disable iff (!rstn)
    (st_q == S_DONE && armed) |=> st_q == S_DONE && !pulse_out_q;
  endproperty
  a_done_hold: assert property (p_done_hold)
    else $error("finished channel reacted to input");

endmodule : gp_counter_decode_pulse

// file: design/gp_counter_pkg.sv
package gp_counter_pkg;

  localparam int CNT_W = 32;

  // Operating modes of the channel
  typedef enum logic [2:0] {
    MODE_QUAD       = 3'h0,
    MODE_TWO_PULSE  = 3'h1,
    MODE_SEP_SINGLE = 3'h2,
    MODE_SEP_BUF    = 3'h3,
    MODE_PULSE      = 3'h4,
    MODE_PULSE_TRIG = 3'h5
  } mode_t;

  // Quadrature decoding factor
  typedef enum logic [1:0] {
    DEC_X1 = 2'h0,
    DEC_X2 = 2'h1,
    DEC_X4 = 2'h2
  } decode_t;

  // Register offsets
  localparam logic [3:0] OFF_CTRL    = 4'h0;
  localparam logic [3:0] OFF_RELOAD  = 4'h1;
  localparam logic [3:0] OFF_DELAY   = 4'h2;
  localparam logic [3:0] OFF_WIDTH   = 4'h3;
  localparam logic [3:0] OFF_COUNT   = 4'h4;
  localparam logic [3:0] OFF_LATCHED = 4'h5;
  localparam logic [3:0] OFF_STATUS  = 4'h6;

  // Control field positions
  localparam int CTRL_ARM      = 0;
  localparam int CTRL_MODE_LO  = 1;
  localparam int CTRL_MODE_HI  = 3;
  localparam int CTRL_DEC_LO   = 4;
  localparam int CTRL_DEC_HI   = 5;
  localparam int CTRL_PH_LO    = 6;
  localparam int CTRL_PH_HI    = 7;
  localparam int CTRL_SRC_FALL = 8;
  localparam int CTRL_AUX_FALL = 9;
  localparam int CTRL_GATE_FALL= 10;
  localparam int CTRL_RLD_EN   = 11;
  localparam int CTRL_W        = 12;

  localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 32'h0000_0001;

  // Register bus request
  typedef struct packed {
    logic [3:0]       addr;
    logic [CNT_W-1:0] wdata;
    logic             wr;
    logic             rd;
  } bus_req_t;

  // Streamed latched count
  typedef struct packed {
    logic             valid;
    logic [CNT_W-1:0] data;
  } stream_t;

endpackage : gp_counter_pkg
